// file: rtl/sfpe_pkg.sv
// Purpose: Shared constants for the serial flash program and erase command path.
// Assumes: A 50 MHz core clock on both ends.
// Notes: Self-timed operation lengths are given in microseconds and turned into cycles by the users.
package sfpe_pkg;
  localparam int CLK_MHZ = 50;
  localparam logic [7:0] OP_LOAD_BUF1 = 8'h84;
  localparam logic [7:0] OP_LOAD_BUF2 = 8'h87;
  localparam logic [7:0] OP_PROG_ERASE_BUF1 = 8'h83;
  localparam logic [7:0] OP_PROG_ERASE_BUF2 = 8'h86;
  localparam logic [7:0] OP_PROG_BUF1 = 8'h88;
  localparam logic [7:0] OP_PROG_BUF2 = 8'h89;
  localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'h50;
  localparam int ADDR_BYTES = 3;
  localparam int HEADER_BYTES = ADDR_BYTES + 1;
  localparam int BUF_BYTES_528 = 528;
  localparam int BUF_BYTES_512 = 512;
  localparam int PAGE_BITS = 12;
  localparam int BUF_INDEX_BITS = 10;
  localparam int PAGE_LSB_528 = 10;
  localparam int PAGE_LSB_512 = 9;
  localparam int BLOCK_LSB = 3;
  localparam int BLOCK_PAGES = 8;
  localparam int ERASE_PROGRAM_TIME_US = 200;
  localparam int PROGRAM_TIME_US = 100;
  localparam int PAGE_ERASE_TIME_US = 100;
  localparam int BLOCK_ERASE_TIME_US = 400;
  localparam int SCK_HALF_CYC = 2;
  localparam int CS_GAP_CYC = 8;
  localparam logic [2:0] SYNC_RESET_HIGH = 3'h7;
  localparam logic [2:0] SYNC_RESET_LOW = 3'h0;
endpackage

// file: rtl/sfpe_link_if.sv
// Purpose: Serial link between the host controller and the flash command device.
// Assumes: Only the serial input direction and the ready/busy line are carried; the serial output pin is not used by these commands.
// Notes: The host makes the serial clock.
`timescale 1ns/1ps
interface sfpe_link_if;
  logic csN;
  logic sck;
  logic si;
  logic rdyBusyN;
  modport host (
    output csN,
    output sck,
    output si,
    input rdyBusyN
  );
  modport dev (
    input csN,
    input sck,
    input si,
    output rdyBusyN
  );
endinterface

// file: rtl/sfpe_device.sv
// Purpose: Device end: takes buffer loads, program and erase commands, runs them self-timed.
// Assumes: The main array sits outside; it is driven through the erase and write strobe ports.
// Notes: Bits are shifted on the link clock; all command decoding runs on mclk.
`timescale 1ns/1ps
module sfpe_device #(
  parameter int ERASE_PROGRAM_CYC = sfpe_pkg::ERASE_PROGRAM_TIME_US * sfpe_pkg::CLK_MHZ,
  parameter int PROGRAM_CYC = sfpe_pkg::PROGRAM_TIME_US * sfpe_pkg::CLK_MHZ,
  parameter int PAGE_ERASE_CYC = sfpe_pkg::PAGE_ERASE_TIME_US * sfpe_pkg::CLK_MHZ,
  parameter int BLOCK_ERASE_CYC = sfpe_pkg::BLOCK_ERASE_TIME_US * sfpe_pkg::CLK_MHZ
) (
  sfpe_link_if.dev link,
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic pageMode512,
  output logic busy,
  output logic memEraseStb,
  output logic [sfpe_pkg::PAGE_BITS-1:0] memErasePage,
  output logic [3:0] memErasePages,
  output logic memWrStb,
  output logic [sfpe_pkg::PAGE_BITS-1:0] memWrPage,
  output logic [sfpe_pkg::BUF_INDEX_BITS-1:0] memWrIndex,
  output logic [7:0] memWrData
);
  import sfpe_pkg::*;
  localparam int MIN_CYC = 2 * BUF_BYTES_528;
  if (ERASE_PROGRAM_CYC < MIN_CYC || PROGRAM_CYC < MIN_CYC || PAGE_ERASE_CYC < 1 || BLOCK_ERASE_CYC < 1 ||
      ERASE_PROGRAM_CYC >= 2**24 || PROGRAM_CYC >= 2**24 || PAGE_ERASE_CYC >= 2**24 ||
      BLOCK_ERASE_CYC >= 2**24) begin : g_bad_timing
    $error("sfpe_device: self-timed cycle counts out of range");
  end
  typedef enum logic [1:0] {ST_IDLE, ST_STREAM, ST_WAIT} sfpe_dstate_type;
  // Last valid buffer location for the current page size.
  function automatic logic [BUF_INDEX_BITS-1:0] lastIndex(input logic m512);
    lastIndex = m512 ? BUF_INDEX_BITS'(BUF_BYTES_512 - 1) : BUF_INDEX_BITS'(BUF_BYTES_528 - 1);
  endfunction

  function automatic logic [BUF_INDEX_BITS-1:0] bufIndex(input logic [23:0] a, input logic m512);
    bufIndex = m512 ? {1'b0, a[PAGE_LSB_512-1:0]} : a[BUF_INDEX_BITS-1:0];
  endfunction

  function automatic logic [PAGE_BITS-1:0] pageNum(input logic [23:0] a, input logic m512);
    pageNum = m512 ? a[PAGE_LSB_512 +: PAGE_BITS] : a[PAGE_LSB_528 +: PAGE_BITS];
  endfunction

  // Link clock domain: only bit assembly lives here, so nothing needs an edge outside a frame.
  logic [6:0] shift_q;
  logic [2:0] bitCnt_q;
  logic [7:0] byte_q;
  logic byteTgl_q;

  always_ff @(posedge link.sck or posedge link.csN) begin
    if (link.csN) begin
      bitCnt_q <= 3'h0;
    end else begin
      bitCnt_q <= bitCnt_q + 3'h1;
    end
  end

  always_ff @(posedge link.sck) begin
    shift_q <= {shift_q[5:0], link.si};
  end

  always_ff @(posedge link.sck or negedge rstn) begin
    if (!rstn) begin
      byte_q <= 8'h00;
      byteTgl_q <= 1'b0;
    end else if (bitCnt_q == 3'h7) begin
      byte_q <= {shift_q, link.si};
      byteTgl_q <= ~byteTgl_q;
    end
  end

  // Core domain: three-stage synchronisers, a change counts once stages two and three agree.
  logic [2:0] csSync_q, tglSync_q;
  logic csLvl_q, tglSeen_q, csAgree, csFall, csRise, byteEv;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      csSync_q <= SYNC_RESET_HIGH;
      tglSync_q <= SYNC_RESET_LOW;
    end else if (ce) begin
      csSync_q <= {csSync_q[1:0], link.csN};
      tglSync_q <= {tglSync_q[1:0], byteTgl_q};
    end
  end

  assign csAgree = csSync_q[1] == csSync_q[2];
  assign csFall = csAgree && !csSync_q[2] && csLvl_q;
  assign csRise = csAgree && csSync_q[2] && !csLvl_q;
  assign byteEv = (tglSync_q[1] == tglSync_q[2]) && (tglSync_q[2] != tglSeen_q);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      csLvl_q <= 1'b1;
      tglSeen_q <= 1'b0;
    end else if (ce) begin
      if (csAgree) begin
        csLvl_q <= csSync_q[2];
      end
      if (tglSync_q[1] == tglSync_q[2]) begin
        tglSeen_q <= tglSync_q[2];
      end
    end
  end

  // Frame parsing: opcode, three address bytes, then data.
  logic [2:0] byteCnt_q;
  logic [7:0] opcode_q;
  logic [23:0] addr_q;
  logic [BUF_INDEX_BITS-1:0] wrIdx_q;
  logic isLoad;
  logic [23:0] addrNext;

  assign isLoad = (opcode_q == OP_LOAD_BUF1) || (opcode_q == OP_LOAD_BUF2);
  assign addrNext = {addr_q[15:0], byte_q};

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      byteCnt_q <= 3'h0;
      opcode_q <= 8'h00;
      addr_q <= 24'h000000;
      wrIdx_q <= '0;
    end else if (ce) begin
      if (csFall) begin
        byteCnt_q <= 3'h0;
      end else if (byteEv) begin
        if (byteCnt_q == 3'h0) begin
          opcode_q <= byte_q;
        end else if (byteCnt_q <= 3'(ADDR_BYTES)) begin
          addr_q <= addrNext;
        end
        if (byteCnt_q == 3'(ADDR_BYTES)) begin
          wrIdx_q <= bufIndex(addrNext, pageMode512);
        end else if (byteCnt_q == 3'(HEADER_BYTES)) begin
          // Indices at or past the last location wrap back to zero.
          wrIdx_q <= (wrIdx_q >= lastIndex(pageMode512)) ? '0 : wrIdx_q + 1'b1;
        end
        if (byteCnt_q != 3'(HEADER_BYTES)) begin
          byteCnt_q <= byteCnt_q + 3'h1;
        end
      end
    end
  end

  // Two SRAM page buffers; loads keep writing until select rises.
  logic [7:0] bufMem [2][BUF_BYTES_528];
  always_ff @(posedge mclk) begin
    if (ce && byteEv && !csLvl_q && byteCnt_q == 3'(HEADER_BYTES) && isLoad &&
        wrIdx_q <= lastIndex(pageMode512)) begin
      bufMem[opcode_q == OP_LOAD_BUF2][wrIdx_q] <= byte_q;
    end
  end

  // Self-timed operations launched on the select rising edge.
  sfpe_dstate_type state_q;
  logic [23:0] timer_q;
  logic progBuf_q, progMode_q;
  logic [BUF_INDEX_BITS-1:0] progIdx_q;
  logic [PAGE_BITS-1:0] progPage_q, curPage;
  logic launch, doErase, doProg;
  logic [23:0] opCyc;
  // Program and erase commands that arrive while busy are dropped without trace.
  assign launch = csRise && byteCnt_q == 3'(HEADER_BYTES) && state_q == ST_IDLE;
  assign curPage = pageNum(addr_q, pageMode512);

  always_comb begin
    doErase = 1'b0;
    doProg = 1'b0;
    opCyc = 24'h000001;
    unique case (opcode_q)
      OP_PROG_ERASE_BUF1, OP_PROG_ERASE_BUF2: begin
        doErase = 1'b1;
        doProg = 1'b1;
        opCyc = 24'(ERASE_PROGRAM_CYC);
      end
      OP_PROG_BUF1, OP_PROG_BUF2: begin
        doProg = 1'b1;
        opCyc = 24'(PROGRAM_CYC);
      end
      OP_PAGE_ERASE: begin
        doErase = 1'b1;
        opCyc = 24'(PAGE_ERASE_CYC);
      end
      OP_BLOCK_ERASE: begin
        doErase = 1'b1;
        opCyc = 24'(BLOCK_ERASE_CYC);
      end
      default: doErase = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      timer_q <= 24'h000000;
      progBuf_q <= 1'b0;
      progMode_q <= 1'b0;
      progIdx_q <= '0;
      progPage_q <= '0;
    end else if (ce) begin
      unique case (state_q)
        ST_IDLE: begin
          if (launch && (doErase || doProg)) begin
            timer_q <= opCyc - 24'h000001;
            progBuf_q <= opcode_q == OP_PROG_ERASE_BUF2 || opcode_q == OP_PROG_BUF2;
            progMode_q <= pageMode512;
            progIdx_q <= '0;
            progPage_q <= pageNum(addr_q, pageMode512);
            state_q <= doProg ? ST_STREAM : ST_WAIT;
          end
        end
        ST_STREAM: begin
          timer_q <= timer_q - 24'h000001;
          progIdx_q <= progIdx_q + 1'b1;
          if (progIdx_q == lastIndex(progMode_q)) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          timer_q <= timer_q - 24'h000001;
          if (timer_q == 24'h000000) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // Erase strobe leads the first write strobe, so the page reads all ones before programming.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      memEraseStb <= 1'b0;
      memErasePage <= '0;
      memErasePages <= 4'h0;
      memWrStb <= 1'b0;
      memWrPage <= '0;
      memWrIndex <= '0;
      memWrData <= 8'h00;
    end else if (ce) begin
      memEraseStb <= state_q == ST_IDLE && launch && doErase;
      // A block erase drops the three low page bits and clears eight pages from the block's base.
      memErasePage <= (opcode_q == OP_BLOCK_ERASE) ? {curPage[PAGE_BITS-1:BLOCK_LSB], 3'h0} : curPage;
      memErasePages <= (opcode_q == OP_BLOCK_ERASE) ? 4'(BLOCK_PAGES) : 4'h1;
      memWrStb <= state_q == ST_STREAM;
      memWrPage <= progPage_q;
      memWrIndex <= progIdx_q;
      memWrData <= bufMem[progBuf_q][progIdx_q];
    end
  end

  assign busy = state_q != ST_IDLE;
  assign link.rdyBusyN = ~busy;
endmodule

// file: rtl/sfpe_host.sv
// Purpose: Host end: frames commands and buffer data onto the serial link.
// Assumes: The caller only sends page programs without erase to pages it has erased.
// Notes: The serial clock is divided from mclk and stands low between frames.
`timescale 1ns/1ps
module sfpe_host #(
  parameter int SCK_HALF = sfpe_pkg::SCK_HALF_CYC,
  parameter int CS_GAP = sfpe_pkg::CS_GAP_CYC
) (
  sfpe_link_if.host link,
  input wire logic mclk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic [7:0] reqOpcode,
  input wire logic [23:0] reqAddr,
  input wire logic wrValid,
  output logic wrReady,
  input wire logic [7:0] wrData,
  input wire logic wrLast,
  output logic devBusy
);
  import sfpe_pkg::*;

  if (SCK_HALF < 1 || SCK_HALF > 255 || CS_GAP < 6 || CS_GAP > 255) begin : g_bad_param
    $error("sfpe_host: divider or gap out of range");
  end

  typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_END, H_GAP} sfpe_hstate_type;

  sfpe_hstate_type state_q;
  logic [31:0] sh_q;
  logic [5:0] bitsLeft_q;
  logic [7:0] div_q;
  logic csN_q;
  logic sck_q;
  logic hasData_q;
  logic last_q;
  logic [2:0] bsySync_q;
  logic tick;
  logic needByte;

  assign tick = div_q == 8'(SCK_HALF - 1);
  assign needByte = state_q == H_SHIFT && bitsLeft_q == 6'h00;
  assign wrReady = needByte && hasData_q && !last_q;
  assign reqReady = state_q == H_IDLE && !devBusy;
  assign link.csN = csN_q;
  assign link.sck = sck_q;
  assign link.si = sh_q[31];

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      bsySync_q <= SYNC_RESET_LOW;
      devBusy <= 1'b0;
    end else if (ce) begin
      bsySync_q <= {bsySync_q[1:0], ~link.rdyBusyN};
      if (bsySync_q[1] == bsySync_q[2]) begin
        devBusy <= bsySync_q[2];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_q <= H_IDLE;
      sh_q <= 32'h00000000;
      bitsLeft_q <= 6'h00;
      div_q <= 8'h00;
      csN_q <= 1'b1;
      sck_q <= 1'b0;
      hasData_q <= 1'b0;
      last_q <= 1'b0;
    end else if (ce) begin
      unique case (state_q)
        H_IDLE: begin
          div_q <= 8'h00;
          if (reqValid && reqReady) begin
            // Page programs without erase go out unchanged; erasing first is the caller's duty.
            sh_q <= {reqOpcode, reqAddr};
            bitsLeft_q <= 6'(8 * HEADER_BYTES);
            hasData_q <= reqOpcode == OP_LOAD_BUF1 || reqOpcode == OP_LOAD_BUF2;
            last_q <= 1'b0;
            csN_q <= 1'b0;
            state_q <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          if (needByte) begin
            div_q <= 8'h00;
            if (wrReady && wrValid) begin
              sh_q <= {wrData, 24'h000000};
              bitsLeft_q <= 6'h08;
              last_q <= wrLast;
            end else if (!hasData_q || last_q) begin
              state_q <= H_END;
            end
          end else if (tick) begin
            div_q <= 8'h00;
            sck_q <= ~sck_q;
            if (sck_q) begin
              // Advance on the falling edge so the device sees a settled bit on the next rise.
              sh_q <= {sh_q[30:0], 1'b0};
              bitsLeft_q <= bitsLeft_q - 6'h01;
            end
          end else begin
            div_q <= div_q + 8'h01;
          end
        end
        H_END: begin
          div_q <= div_q + 8'h01;
          if (tick) begin
            csN_q <= 1'b1;
            div_q <= 8'h00;
            state_q <= H_GAP;
          end
        end
        H_GAP: begin
          div_q <= div_q + 8'h01;
          // With CS_GAP of 8 or more the gap outlasts both synchronisers so busy is seen before the next request; 6 and 7 are accepted but fall short.
          if (div_q == 8'(CS_GAP - 1)) begin
            state_q <= H_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// file: bench/sfpe_link_monitor.sv
// Purpose: Concurrent checks on the serial link between host and device ends.
// Assumes: Sampled on mclk, which runs far faster than the serial clock.
// Notes: Busy bounds follow the shortened self-timed counts of the bench.
`timescale 1ns/1ps
module sfpe_link_monitor #(
  parameter int MIN_BUSY = 20,
  parameter int MAX_BUSY = 1150
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic csN,
  input wire logic sck,
  input wire logic si,
  input wire logic rdyBusyN
);
  logic sckQ;
  logic [12:0] bitCntQ;
  logic [10:0] busyCntQ;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  always_ff @(posedge mclk) begin
    if (!rstn || csN) begin
      bitCntQ <= 13'h0000;
    end else if (sck && !sckQ) begin
      bitCntQ <= bitCntQ + 13'h0001;
    end
  end
  always_ff @(posedge mclk) begin
    sckQ <= sck;
  end
  // Saturates so a hung device still trips the bound instead of wrapping.
  always_ff @(posedge mclk) begin
    if (!rstn || rdyBusyN) begin
      busyCntQ <= 11'h000;
    end else if (busyCntQ != 11'h7FF) begin
      busyCntQ <= busyCntQ + 11'h001;
    end
  end
  sequence s_frame_open;
    !sck ##1 !sck;
  endsequence
  sequence s_sck_pulse;
    sck [*2] ##1 !sck;
  endsequence
  property p_sck_idle; csN |-> !sck; endproperty
  property p_cs_start; $fell(csN) |-> s_frame_open; endproperty
  property p_sck_half; $rose(sck) |-> s_sck_pulse; endproperty
  property p_si_hold; sck |-> $stable(si); endproperty
  property p_frame_bits; $rose(csN) |-> bitCntQ >= 13'd32 && bitCntQ[2:0] == 3'h0; endproperty
  property p_cs_gap; $rose(csN) |-> csN [*6]; endproperty
  property p_busy_after_cs; $fell(rdyBusyN) |-> csN && $past(csN, 3); endproperty
  property p_busy_max; busyCntQ <= MAX_BUSY; endproperty
  property p_busy_min; $rose(rdyBusyN) |-> busyCntQ >= MIN_BUSY - 1; endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("serial clock moved outside a frame");
  a_cs_start: assert property (p_cs_start) else $error("frame opened with serial clock high");
  a_sck_half: assert property (p_sck_half) else $error("serial clock high phase wrong");
  a_si_hold: assert property (p_si_hold) else $error("serial data changed while clock high");
  a_frame_bits: assert property (p_frame_bits) else $error("frame not whole bytes after header");
  a_cs_gap: assert property (p_cs_gap) else $error("select gap too short");
  a_busy_after_cs: assert property (p_busy_after_cs) else $error("busy began inside a frame");
  a_busy_max: assert property (p_busy_max) else $error("busy pin held too long");
  a_busy_min: assert property (p_busy_min) else $error("busy pin released too early");
endmodule

// file: bench/tb.sv
// Purpose: Drives the host end and judges the device end's memory strobes.
// Assumes: Shortened self-timed counts; the serial clock comes from the host divider.
// Notes: Buffer contents are seen only through the program write strobes.
`timescale 1ns/1ps
module tb;
  import sfpe_pkg::*;
  localparam int PROG_CYC = 1100;
  localparam int ERASE_CYC = 20;
  logic mclk = 1'b0;
  logic rstn = 1'b1;
  logic ce = 1'b1;
  logic pageMode512 = 1'b0;
  logic reqValid = 1'b0;
  logic [7:0] reqOpcode = 8'h00;
  logic [23:0] reqAddr = 24'h000000;
  logic wrValid = 1'b0;
  logic [7:0] wrData = 8'h00;
  logic wrLast = 1'b0;
  logic reqReady, wrReady, devBusy, busy, memEraseStb, memWrStb;
  logic [11:0] memErasePage, memWrPage, wrPageSeen, ersPage;
  logic [3:0] memErasePages, ersPages;
  logic [9:0] memWrIndex;
  logic [7:0] memWrData;
  logic [7:0] wrSeen [0:1023];
  int wrCnt, ersCnt, cycles, err_count, checks_done;
  sfpe_link_if link();
  sfpe_host u_sfpe_host (.link(link), .mclk(mclk), .rstn(rstn), .ce(ce), .reqValid(reqValid),
    .reqReady(reqReady), .reqOpcode(reqOpcode), .reqAddr(reqAddr), .wrValid(wrValid), .wrReady(wrReady),
    .wrData(wrData), .wrLast(wrLast), .devBusy(devBusy));
  sfpe_device #(.ERASE_PROGRAM_CYC(PROG_CYC), .PROGRAM_CYC(PROG_CYC), .PAGE_ERASE_CYC(ERASE_CYC),
    .BLOCK_ERASE_CYC(ERASE_CYC)) u_sfpe_device (.link(link), .mclk(mclk), .rstn(rstn), .ce(ce),
    .pageMode512(pageMode512), .busy(busy), .memEraseStb(memEraseStb), .memErasePage(memErasePage),
    .memErasePages(memErasePages), .memWrStb(memWrStb), .memWrPage(memWrPage), .memWrIndex(memWrIndex),
    .memWrData(memWrData));
  sfpe_link_monitor #(.MIN_BUSY(ERASE_CYC), .MAX_BUSY(PROG_CYC + 50)) u_sfpe_link_monitor (.mclk(mclk),
    .rstn(rstn), .csN(link.csN), .sck(link.sck), .si(link.si), .rdyBusyN(link.rdyBusyN));
  always #10 mclk = ~mclk;
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Records device strobes; the run is cut off well past the longest expected sequence.
  always @(posedge mclk) begin
    cycles++;
    if (memWrStb === 1'b1) begin
      wrCnt++;
      wrSeen[memWrIndex] = memWrData;
      wrPageSeen = memWrPage;
    end
    if (memEraseStb === 1'b1) begin
      ersCnt++;
      ersPage = memErasePage;
      ersPages = memErasePages;
    end
    if (cycles > 60000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  function automatic logic [23:0] page_addr(input logic m, input logic [11:0] pg);
    return m ? {3'h7, pg, 9'h1FF} : {2'h3, pg, 10'h3FF};
  endfunction
  task automatic send(input logic [7:0] op, input logic [23:0] addr, input int n, input logic [7:0] base);
    int k;
    reqOpcode = op;
    reqAddr = addr;
    reqValid = 1'b1;
    for (k = 0; k < 5000 && reqReady !== 1'b1; k++) tick();
    tick();
    reqValid = 1'b0;
    for (int i = 0; i < n; i++) begin
      wrData = base + 8'(i);
      wrLast = (i == n - 1);
      wrValid = 1'b1;
      for (k = 0; k < 500 && wrReady !== 1'b1; k++) tick();
      tick();
    end
    wrValid = 1'b0;
    wrLast = 1'b0;
  endtask
  task automatic idle();
    for (int k = 0; k < 5000 && reqReady !== 1'b1; k++) tick();
  endtask
  // Launches a self-timed command and measures how long busy stands.
  task automatic run_op(input logic [7:0] op, input logic [23:0] addr, input int cyc);
    int b;
    wrCnt = 0;
    ersCnt = 0;
    send(op, addr, 0, 8'h00);
    for (b = 0; b < 200 && busy !== 1'b1; b++) tick();
    for (b = 0; b < 5000 && busy === 1'b1; b++) begin
      if (b == 10) check(devBusy, 1'b1);
      tick();
    end
    check(b >= cyc - 2 && b <= cyc + 2, 1'b1);
    idle();
  endtask
  task automatic sc_prog(input logic m, input logic [7:0] op, input logic [11:0] pg, input logic ers);
    pageMode512 = m;
    run_op(op, page_addr(m, pg), PROG_CYC);
    check(ersCnt, ers);
    if (ers) check({ersPage, ersPages}, {pg, 4'h1});
    check(wrCnt, m ? BUF_BYTES_512 : BUF_BYTES_528);
    check(wrPageSeen, pg);
  endtask
  task automatic sc_erase(input logic m, input logic [7:0] op, input logic [11:0] pg, input logic [15:0] exp);
    pageMode512 = m;
    run_op(op, page_addr(m, pg), ERASE_CYC);
    check({ersCnt[3:0], ersPage, ersPages}, {4'h1, exp});
    check(wrCnt, 0);
  endtask
  task automatic sc_load(input logic m, input logic [7:0] op, input logic [23:0] a, input int n, input logic [7:0] b);
    pageMode512 = m;
    send(op, a, n, b);
    idle();
  endtask
  initial begin
    // A real falling edge is needed so the link-side byte flops take their asynchronous reset.
    #1 rstn = 1'b0;
    repeat (10) @(posedge mclk);
    #1;
    rstn = 1'b1;
    tick();
    // Loads start near the top index with the ignored address bits set, so wrap and masking both show.
    sc_load(1'b0, OP_LOAD_BUF1, 24'hFFFE0E, 4, 8'hA0);
    sc_prog(1'b0, OP_PROG_ERASE_BUF1, 12'hABC, 1'b1);
    check({wrSeen[526], wrSeen[527], wrSeen[0], wrSeen[1]}, 32'hA0A1A2A3);
    sc_load(1'b1, OP_LOAD_BUF2, 24'hFFFFFF, 3, 8'hB0);
    sc_erase(1'b1, OP_PAGE_ERASE, 12'h5A3, {12'h5A3, 4'h1});
    sc_prog(1'b1, OP_PROG_BUF2, 12'h5A3, 1'b0);
    check({wrSeen[511], wrSeen[0], wrSeen[1]}, 24'hB0B1B2);
    sc_erase(1'b0, OP_PAGE_ERASE, 12'h001, {12'h001, 4'h1});
    sc_prog(1'b0, OP_PROG_BUF1, 12'h001, 1'b0);
    check(wrSeen[0], 8'hA2);
    sc_prog(1'b1, OP_PROG_ERASE_BUF2, 12'hFFF, 1'b1);
    check(wrSeen[0], 8'hB1);
    sc_erase(1'b0, OP_PAGE_ERASE, 12'h7FE, {12'h7FE, 4'h1});
    sc_erase(1'b1, OP_PAGE_ERASE, 12'h001, {12'h001, 4'h1});
    sc_erase(1'b0, OP_BLOCK_ERASE, 12'hFFF, {12'hFF8, 4'h8});
    sc_erase(1'b1, OP_BLOCK_ERASE, 12'h00F, {12'h008, 4'h8});
    finish_test();
  end
endmodule
